// >>> flow_through_sync_sram_port_tb_top.sv
// Self-checking bench for the SRAM port: writes, bursts, pads, output control, status.
`timescale 1ns/1ps
`default_nettype none
module flow_through_sync_sram_port_tb_top;
    import srp_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, oe_n, cs1_n, cs2, cs3_n, dq_oe, par_oe, mz;
    logic        proc_as_n, ctrl_as_n, step_n, all_wr_n, gate_n, sleep_req, mode_pad;
    logic [1:0]  htrans, last_off;
    logic [2:0]  hsize;
    logic [3:0]  lane_n, par_i, par_o;
    logic [17:0] addr, base;
    logic [31:0] haddr, hwdata, hrdata, dq_i, dq_o, seed, rd;
    logic [35:0] mem [4];
    int          err_count, check_count;
    srp_port dut
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .addr(addr), .processor_addr_strobe_n(proc_as_n), .controller_addr_strobe_n(ctrl_as_n),
        .burst_step_n(step_n), .chip_select_primary_n(cs1_n), .chip_select_high(cs2), .chip_select_low_n(cs3_n),
        .byte_write_gate_n(gate_n), .byte_lane_write_select_n(lane_n), .all_byte_write_n(all_wr_n),
        .output_enable_n(oe_n), .sleep_request(sleep_req), .burst_order_sel(mode_pad), .dq_i(dq_i),
        .dq_o(dq_o), .dq_oe(dq_oe), .parity_io_lines_i(par_i), .parity_io_lines_o(par_o), .parity_io_lines_oe(par_oe)
    );
    srp_host_model host
    (
        .hclk(hclk), .dq_o(dq_o), .dq_oe(dq_oe), .par_o(par_o), .par_oe(par_oe), .addr(addr),
        .proc_as_n(proc_as_n), .ctrl_as_n(ctrl_as_n), .step_n(step_n), .all_wr_n(all_wr_n), .gate_n(gate_n),
        .lane_n(lane_n), .sleep_req(sleep_req), .mode_pad(mode_pad), .dq_i(dq_i), .par_i(par_i)
    );
    // 100 MHz clock.
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Xorshift source, fixed seed so that every run is the same.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Burst offset after k steps from start s.
    function automatic logic [1:0] exp_off(input logic [1:0] s, input logic [1:0] k);
        return mz ? (s ^ k) : 2'(s + k);
    endfunction
    // Bits a write touches: a lane is eight data bits plus its parity bit.
    function automatic logic [35:0] lane_mask(input logic g, input logic b, input logic [3:0] w);
        lane_mask = '0;
        for (int i = 0; i < 4; i++)
            if (!g || (!b && !w[i]))
                lane_mask |= {4'(1) << i, 32'hff << (8 * i)};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic tally(input logic bad, input string what);
        check_count++;
        if (bad)
        begin
            err_count++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask
    task automatic cmp_data(input logic [35:0] got, input logic [35:0] exp);
        tally(got !== exp, $sformatf("data %h not %h", got, exp));
    endtask
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        tally(got !== exp, $sformatf("register %h not %h", got, exp));
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        tally(got !== exp, $sformatf("flag %b not %b", got, exp));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Bounded wait for ready; running out ends the run.
    task automatic wait_rdy();
        int n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1)
        begin
            tally(1'b1, "bus wait ran out");
            give_verdict();
        end
    endtask
    // One single AHB word: address phase, then data phase; read data lands in rd.
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, haddr, hwrite} <= {1'b1, HTRANS_NONSEQ, a, w};
        wait_rdy();
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic stat(input logic [31:0] mask, input logic [31:0] exp);
        ahb(1'b0, OFF_STATUS, '0);
        cmp_reg(rd & mask, exp);
        cmp_flag(hresp, 1'b0);
    endtask
    task automatic idle(input int n);
        repeat (n) host.cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, '0, '0);
    endtask
    // Write at base+i, then release the pins so the strobe is not seen again; memory follows only if taken.
    task automatic wr(input logic p, input logic g, input logic b, input logic [3:0] w,
                      input logic [1:0] i, input logic take);
        logic [35:0] d;
        logic [35:0] m;
        d = {4'(rnd()), rnd()};
        m = take ? lane_mask(g, b, w) : '0;
        host.cyc(p, 1'b0, 1'b1, g, b, w, base | 18'(i), d);
        idle(1);
        mem[i] = (mem[i] & ~m) | (d & m);
    endtask
    // Four-beat read burst from base+s; oe0 is the drive expected on the first beat.
    task automatic burst(input logic p, input logic [1:0] s, input logic oe0);
        host.cyc(p, ~p, 1'b1, 1'b1, 1'b1, 4'hf, base | 18'(s), '0);
        for (int k = 0; k < 4; k++)
        begin
            host.cyc(1'b1, 1'b1, k == 3, 1'b1, 1'b1, 4'hf, '0, '0);
            cmp_data({par_o, dq_o}, mem[exp_off(s, 2'(k))]);
            cmp_flag(dq_oe, k == 0 ? oe0 : 1'b1);
            cmp_flag(par_oe, k == 0 ? oe0 : 1'b1);
        end
        last_off = exp_off(s, 2'h3);
    endtask
    // The strap only changes while reset is held.
    task automatic do_reset(input logic z, input logic v);
        hresetn <= 1'b0;
        host.pads(1'b1, 1'b0, z, v);
        mz = z | v;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask
    task automatic run_pass();
        idle(2);
        for (int i = 0; i < 4; i++)
            wr(1'b1, 1'b0, 1'b1, 4'hf, 2'(i), 1'b1);
        repeat (6) wr(1'b1, 1'b1, 1'b0, 4'(rnd()), 2'(rnd()), 1'b1);
        wr(1'b1, 1'b1, 1'b1, 4'h0, 2'(rnd()), 1'b0);
        wr(1'b0, 1'b1, 1'b0, 4'h0, 2'(rnd()), 1'b0);
        oe_n <= 1'b0;
        idle(2);
        repeat (4) burst(1'(rnd()), 2'(rnd()), 1'b1);
        stat(32'h00ff_ff37, {8'h0, base[17:2], 2'h0, last_off, 1'b0, mz, 2'h0});
        oe_n <= 1'b1;
        idle(2);
        host.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, base, '0);
        idle(1);
        cmp_flag(dq_oe, 1'b0);
        cmp_flag(par_oe, 1'b0);
        $display("test pass with order %b done", mz);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {seed, err_count, check_count} = {32'hc1c1, 32'd0, 32'd0};
        {hresetn, hsel, hwrite, oe_n, cs1_n, cs2, cs3_n, htrans, hsize, haddr, hwdata} = {12'b000101000010, 64'h0};
        do_reset(1'b1, 1'b0);
        base = {16'(rnd()), 2'h0};
        run_pass();
        // Processor strobe with the primary select high must not capture.
        cs1_n <= 1'b1;
        host.cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, ~base, '0);
        idle(1);
        cs1_n <= 1'b0;
        stat(32'h00ff_ff03, {8'h0, base[17:2], 8'h0});
        // Sleep blocks writes and keeps the array; the pull-down wakes it.
        host.pads(1'b0, 1'b1, host.mod_z, host.mod_v);
        idle(2);
        wr(1'b1, 1'b0, 1'b1, 4'hf, 2'h1, 1'b0);
        stat(32'h1, 32'h1);
        host.pads(1'b1, 1'b0, host.mod_z, host.mod_v);
        idle(2);
        // Write inhibit in the control word, then an unmapped read.
        ahb(1'b1, OFF_CTRL, 32'h1);
        ahb(1'b0, OFF_CTRL, '0);
        cmp_reg(rd, 32'h1);
        wr(1'b1, 1'b0, 1'b1, 4'hf, 2'h2, 1'b0);
        ahb(1'b1, OFF_CTRL, 32'h0);
        ahb(1'b0, 32'h8, '0);
        cmp_reg(rd, 32'h0);
        // Deselect floats the pins; the first read after it stays floating too.
        oe_n <= 1'b0;
        cs2 <= 1'b0;
        host.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, base, '0);
        idle(1);
        cmp_flag(dq_oe, 1'b0);
        cs2 <= 1'b1;
        stat(32'h2, 32'h2);
        burst(1'b1, 2'h1, 1'b0);
        oe_n <= 1'b1;
        $display("test sleep, select and registers done");
        do_reset(1'b0, 1'b0);
        run_pass();
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> srp_burst_ctr.sv
// Two-bit burst counter with linear or interleaved order.
`timescale 1ns/1ps
`default_nettype none
module srp_burst_ctr
    import srp_pkg::*;
(
    input  wire logic       hclk,     // Clock.
    input  wire logic       hresetn,  // Asynchronous reset, active low.
    input  wire logic       load,     // Load a new burst start.
    input  wire logic [1:0] load_val, // Low address bits to load.
    input  wire logic       burst_step,      // Step the burst.
    input  wire logic       ilv,      // Interleaved order when high.
    output var  logic [1:0] off_nx,   // Offset after this edge.
    output var  logic [1:0] off_q     // Current offset.
);
    import srp_pkg::*;

    typedef struct packed {
        logic [1:0] start;
        logic [1:0] step;
    } srp_ctr_t;

    srp_ctr_t s_q;
    srp_ctr_t s_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Load wins over stepping; the count wraps within four words.
    always_comb
    begin
        s_d = s_q;
        if (load)
        begin
            s_d.start = load_val;
            s_d.step  = 2'h0;
        end
        else if (burst_step)
        begin
            s_d.step = 2'(s_q.step + 2'h1);
        end
        off_nx = srp_burst_off(s_d.start, s_d.step, ilv);
        off_q  = srp_burst_off(s_q.start, s_q.step, ilv);
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

endmodule
`default_nettype wire

// >>> srp_host_model.sv
// Host model: drives the SRAM port pins and resolves the shared pads.
`timescale 1ns/1ps
`default_nettype none
module srp_host_model
(
    input  wire logic                       hclk,      // Clock.
    input  wire logic [srp_pkg::DATA_W-1:0] dq_o,      // Device data.
    input  wire logic                       dq_oe,     // Device drives data.
    input  wire logic [srp_pkg::LANES-1:0]  par_o,     // Device parity.
    input  wire logic                       par_oe,    // Device drives parity.
    output var  logic [srp_pkg::ADDR_W-1:0] addr,      // Address.
    output var  logic                       proc_as_n, // Processor strobe.
    output var  logic                       ctrl_as_n, // Controller strobe.
    output var  logic                       step_n,    // Burst step.
    output var  logic                       all_wr_n,  // All byte write.
    output var  logic                       gate_n,    // Byte write gate.
    output var  logic [srp_pkg::LANES-1:0]  lane_n,    // Lane selects.
    output wire logic                       sleep_req, // Sleep pad level.
    output wire logic                       mode_pad,  // Strap pad level.
    output wire logic [srp_pkg::DATA_W-1:0] dq_i,      // Data pad level.
    output wire logic [srp_pkg::LANES-1:0]  par_i      // Parity pad level.
);
    import srp_pkg::*;
    logic [WORD_W-1:0] wd_q;
    logic              drv_q, tick_q, slp_z, slp_v, mod_z, mod_v;
    // Quiet pins at time zero; both pads start floating.
    initial
    begin
        {proc_as_n, ctrl_as_n, step_n, all_wr_n, gate_n, lane_n} = '1;
        addr = '0;
        wd_q = '0;
        {drv_q, tick_q, slp_z, slp_v, mod_z, mod_v} = 6'b001010;
    end
    // Pads: sleep has a pull-down, the strap a pull-up.
    assign sleep_req = slp_z ? 1'b0 : slp_v;
    assign mode_pad  = mod_z ? 1'b1 : mod_v;
    // Undriven lines toggle so that a stale value never passes for data.
    always @(posedge hclk)
        tick_q <= ~tick_q;
    assign dq_i  = dq_oe ? dq_o : (drv_q ? wd_q[31:0] : {16{tick_q, ~tick_q}});
    assign par_i = par_oe ? par_o : (drv_q ? wd_q[35:32] : {2{tick_q, ~tick_q}});
    // One pin cycle, changed just after an edge and held until the next.
    task automatic cyc(input logic p, input logic c, input logic s, input logic g, input logic b,
                       input logic [3:0] w, input logic [17:0] a, input logic [35:0] d);
        @(posedge hclk);
        {proc_as_n, ctrl_as_n, step_n, all_wr_n, gate_n, lane_n} <= {p, c, s, g, b, w};
        addr  <= a;
        wd_q  <= d;
        drv_q <= ~(g & b);
        #1;
    endtask
    // Pad drive; a floating pad falls back to its pull.
    task automatic pads(input logic sz, input logic sv, input logic mz, input logic mv);
        {slp_z, slp_v, mod_z, mod_v} <= {sz, sv, mz, mv};
    endtask
endmodule
`default_nettype wire

// >>> srp_mem.sv
// Storage array with per-lane write enables and a registered read port.
`timescale 1ns/1ps
`default_nettype none
module srp_mem
    import srp_pkg::*;
(
    input  wire logic              hclk,    // Clock.
    input  wire logic              hresetn, // Asynchronous reset, active low.
    input  wire logic              we,      // Write the pending word.
    input  wire logic [LANES-1:0]  wlane,   // Lanes to write.
    input  wire logic [ADDR_W-1:0] waddr,   // Write address.
    input  wire logic [WORD_W-1:0] wdata,   // Parity in the top four bits.
    input  wire logic              re,      // Read this edge.
    input  wire logic [ADDR_W-1:0] raddr,   // Read address.
    output var  logic [WORD_W-1:0] rdata_q  // Read data, held between reads.
);
    import srp_pkg::*;

    // The array has no reset, so contents survive sleep and deselection.
    logic [WORD_W-1:0] mem [0:(1 << ADDR_W)-1];

    ////////////////////////////////////////////////////////////////////////////////
    // Each lane writes its own byte and its own parity bit.
    always_ff @(posedge hclk)
    begin
        for (int i = 0; i < LANES; i++)
        begin
            if (we && wlane[i])
            begin
                mem[waddr][8*i +: 8]     <= wdata[8*i +: 8];
                mem[waddr][DATA_W + i]   <= wdata[DATA_W + i];
            end
        end
    end

    // Flow-through read: data from the address given at this edge.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_q <= '0;
        else if (re)
            rdata_q <= mem[raddr];
    end

endmodule
`default_nettype wire

// >>> srp_pkg.sv
// Shared constants, types and helpers for the flow-through synchronous SRAM port.
package srp_pkg;

    // Array geometry.
    localparam int ADDR_W  = 18;
    localparam int LANES   = 4;
    localparam int DATA_W  = 32;
    localparam int WORD_W  = DATA_W + LANES;
    localparam int BASE_W  = ADDR_W - 2;

    // Register map on the AHB-Lite side.
    localparam logic [31:0] OFF_CTRL   = 32'h0000_0000;
    localparam logic [31:0] OFF_STATUS = 32'h0000_0004;
    localparam logic [31:0] OFF_MASK   = 32'h0000_000c;
    localparam logic [0:0]  CTRL_RESET = 1'h0;

    // Status field positions.
    localparam int ST_SLEEP_BIT = 0;
    localparam int ST_DESEL_BIT = 1;
    localparam int ST_ILV_BIT   = 2;
    localparam int ST_OFF_LSB   = 4;
    localparam int ST_BASE_LSB  = 8;

    // AHB transfer types.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Port state.
    typedef enum logic [1:0] {SRP_DESEL, SRP_ACTIVE, SRP_SLEEP} srp_state_t;

    // Burst offset for a given start and step count.
    function automatic logic [1:0] srp_burst_off(input logic [1:0] start, input logic [1:0] step,
                                                 input logic ilv);
        srp_burst_off = ilv ? (start ^ step) : 2'(start + step);
    endfunction

endpackage

// >>> srp_port.sv
// Top of the flow-through synchronous SRAM port with an AHB-Lite status slave.
// Operation
// - Controller strobe low at an edge captures the address.
// - Every capture loads address bits one and zero into the burst counter.
// - With both strobes low and the primary select low, only the processor strobe acts.
// - Lane writes happen only with the byte write gate or all byte write sampled low.
// - Sleep request high enters a quiet sleep state keeping stored data.
// - Sleep must be low for normal work; the pad pulls it down.
// - Input data is registered into a data register at the edge.
// - Reads drive data of the address given at the previous edge.
// - Data and parity drive while output enable is low, else float.
// - Outputs float in the first clock after leaving deselection.
// - Deselected device keeps data and parity floating.
// - Parity lanes follow data lanes and their byte selects on writes.
// - Strap low selects linear burst order.
// - Strap high or floating selects interleaved order; the pad pulls it up.
// - Burst step low at an edge advances the burst address.
// - All byte write low writes every lane regardless of selects and gate.
// - Processor strobe is ignored while primary chip select is high.
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module srp_port
    import srp_pkg::*;
(
    input  wire logic                    hclk,                     // Clock, 100 MHz.
    input  wire logic                    hresetn,                  // Asynchronous reset, active low.
    input  wire logic                    hsel,                     // AHB slave select.
    input  wire logic [31:0]             haddr,                    // AHB address.
    input  wire logic [1:0]              htrans,                   // AHB transfer type.
    input  wire logic                    hwrite,                   // AHB write.
    input  wire logic [2:0]              hsize,                    // AHB size.
    input  wire logic [31:0]             hwdata,                   // AHB write data.
    input  wire logic                    hready,                   // AHB ready in.
    output var  logic                    hreadyout,                // AHB ready out.
    output var  logic [31:0]             hrdata,                   // AHB read data.
    output var  logic                    hresp,                    // AHB response, always OKAY.
    input  wire logic [srp_pkg::ADDR_W-1:0] addr,                  // Memory address.
    input  wire logic                    processor_addr_strobe_n,  // Processor strobe.
    input  wire logic                    controller_addr_strobe_n, // Controller strobe.
    input  wire logic                    burst_step_n,             // Advance burst.
    input  wire logic                    chip_select_primary_n,    // Primary chip select.
    input  wire logic                    chip_select_high,         // Second chip select.
    input  wire logic                    chip_select_low_n,        // Third chip select.
    input  wire logic                    byte_write_gate_n,        // Byte write gate.
    input  wire logic [srp_pkg::LANES-1:0] byte_lane_write_select_n, // Lane selects.
    input  wire logic                    all_byte_write_n,         // Write all lanes.
    input  wire logic                    output_enable_n,          // Output enable.
    input  wire logic                    sleep_request,            // Sleep, active high.
    input  wire logic                    burst_order_sel,          // Strap, high = interleaved.
    input  wire logic [srp_pkg::DATA_W-1:0] dq_i,                  // Data pins in.
    output var  logic [srp_pkg::DATA_W-1:0] dq_o,                  // Data pins out.
    output var  logic                    dq_oe,                    // Data pins drive.
    input  wire logic [srp_pkg::LANES-1:0] parity_io_lines_i,      // Parity pins in.
    output var  logic [srp_pkg::LANES-1:0] parity_io_lines_o,      // Parity pins out.
    output var  logic                    parity_io_lines_oe        // Parity pins drive.
);
    import srp_pkg::*;

    typedef struct packed {
        srp_state_t         state;
        logic [BASE_W-1:0]  base;
        logic               ilv;
        logic               strap_taken;
        logic               oe;
        logic               wr;
        logic [LANES-1:0]   wlane;
        logic [ADDR_W-1:0]  waddr;
        logic [WORD_W-1:0]  wdata;
        logic               wr_inhibit;
        logic               ahb_act;
        logic               ahb_wr;
        logic [31:0]        ahb_addr;
        logic               readyout;
        logic [31:0]        rdata;
    } srp_top_t;

    srp_top_t s_q;
    srp_top_t s_d;

    logic              ads_p;
    logic              ads_c;
    logic              capture;
    logic              sel_now;
    logic              burst_step;
    logic              wr_now;
    logic              rd_now;
    logic [LANES-1:0]  lanes;
    logic [1:0]        off_nx;
    logic [1:0]        off_q;
    logic [WORD_W-1:0] rword;

    ////////////////////////////////////////////////////////////////////////////////
    // Strobe decode. The processor strobe needs the primary select low and wins a tie.
    always_comb
    begin
        ads_p   = !processor_addr_strobe_n && !chip_select_primary_n;
        ads_c   = !controller_addr_strobe_n && !ads_p;
        sel_now = !chip_select_primary_n && chip_select_high && !chip_select_low_n;
        capture = (ads_p || ads_c) && !sleep_request;
        burst_step     = !capture && !burst_step_n && s_q.state == SRP_ACTIVE;
    end

    // Lane write enables; all-byte write overrides selects and the gate.
    always_comb
    begin
        if (!all_byte_write_n)
            lanes = '1;
        else if (!byte_write_gate_n)
            lanes = ~byte_lane_write_select_n;
        else
            lanes = '0;
    end

    srp_burst_ctr u_ctr (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .load     (capture),
        .load_val (addr[1:0]),
        .burst_step      (burst_step),
        .ilv      (s_q.ilv),
        .off_nx   (off_nx),
        .off_q    (off_q)
    );

    srp_mem u_mem (
        .hclk    (hclk),
        .hresetn (hresetn),
        .we      (s_q.wr),
        .wlane   (s_q.wlane),
        .waddr   (s_q.waddr),
        .wdata   (s_q.wdata),
        .re      (rd_now),
        .raddr   ({s_d.base, off_nx}),
        .rdata_q (rword)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Port sequencing. A cycle opened by the processor strobe is always a read start,
    // which keeps its write controls from landing on a stale address.
    always_comb
    begin
        s_d    = s_q;
        wr_now = 1'b0;
        rd_now = 1'b0;
        // The strap is caught once after reset and then held.
        if (!s_q.strap_taken)
        begin
            s_d.strap_taken = 1'b1;
            s_d.ilv         = burst_order_sel;
        end
        if (sleep_request)
        begin
            s_d.state = SRP_SLEEP;
        end
        else if (capture)
        begin
            s_d.state = sel_now ? SRP_ACTIVE : SRP_DESEL;
            if (sel_now)
                s_d.base = addr[ADDR_W-1:2];
        end
        else if (s_q.state == SRP_SLEEP)
        begin
            s_d.state = SRP_DESEL;
        end
        if (s_d.state == SRP_ACTIVE)
        begin
            wr_now = !ads_p && (lanes != '0) && !s_q.wr_inhibit;
            rd_now = !wr_now;
        end
        // Write data is taken into the data register; the array takes it next edge.
        s_d.wr    = wr_now;
        s_d.wlane = lanes;
        s_d.waddr = capture ? {s_d.base, addr[1:0]} : {s_q.base, off_q};
        s_d.wdata = {parity_io_lines_i, dq_i};
        // Drive only on reads, never right after deselection or while deselected.
        s_d.oe = rd_now && !output_enable_n
                 && !(capture && s_q.state != SRP_ACTIVE);

        // AHB-Lite slave: zero wait states, OKAY to everything.
        s_d.readyout = 1'b1;
        if (s_q.ahb_act && s_q.ahb_wr && s_q.ahb_addr == OFF_CTRL)
            s_d.wr_inhibit = hwdata[0];
        s_d.ahb_act = hsel && hready && htrans == HTRANS_NONSEQ;
        if (hready)
        begin
            s_d.ahb_wr   = hwrite;
            s_d.ahb_addr = {haddr[31:2], 2'h0};
        end
        if (s_d.ahb_act && !hwrite)
        begin
            case ({haddr[31:2], 2'h0})
                OFF_CTRL:   s_d.rdata = {31'h0, s_q.wr_inhibit};
                OFF_STATUS:
                begin
                    s_d.rdata                             = 32'h0;
                    s_d.rdata[ST_SLEEP_BIT]               = s_q.state == SRP_SLEEP;
                    s_d.rdata[ST_DESEL_BIT]               = s_q.state == SRP_DESEL;
                    s_d.rdata[ST_ILV_BIT]                 = s_q.ilv;
                    s_d.rdata[ST_OFF_LSB +: 2]            = off_q;
                    s_d.rdata[ST_BASE_LSB +: BASE_W]      = s_q.base;
                end
                default:    s_d.rdata = 32'h0;
            endcase
        end
    end

    // State register; the array itself is untouched by reset.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_q            <= '0;
            s_q.state      <= SRP_DESEL;
            s_q.ilv        <= 1'b1;
            s_q.wr_inhibit <= CTRL_RESET[0];
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops, except hresp, which is tied low.
    assign dq_o               = rword[DATA_W-1:0];
    assign parity_io_lines_o  = rword[WORD_W-1:DATA_W];
    assign dq_oe              = s_q.oe;
    assign parity_io_lines_oe = s_q.oe;
    assign hreadyout          = s_q.readyout;
    assign hrdata             = s_q.rdata;
    assign hresp              = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence leave_desel;
        s_q.state == SRP_DESEL && capture && sel_now;
    endsequence

    sequence ilv_load_one;
        s_q.ilv && capture && sel_now && addr[1:0] == 2'h1 && !sleep_request;
    endsequence

    chk_capture_addr: assert property (@(posedge hclk) disable iff (!hresetn)
        (capture && sel_now) |=> (s_q.base == $past(addr[ADDR_W-1:2])))
        else $error("captured base address is wrong");

    chk_counter_load: assert property (@(posedge hclk) disable iff (!hresetn)
        (capture && sel_now && !s_q.ilv) |=> (off_q == $past(addr[1:0])))
        else $error("burst counter did not load low address bits");

    chk_processor_addr_strobe_wins: assert property (@(posedge hclk) disable iff (!hresetn)
        (ads_p && !controller_addr_strobe_n && !sleep_request) |=> !s_q.wr)
        else $error("processor strobe tie did not start a read");

    chk_write_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        s_q.wr |-> $past(!all_byte_write_n || !byte_write_gate_n))
        else $error("write without gate or all-byte write");

    chk_all_bytes: assert property (@(posedge hclk) disable iff (!hresetn)
        (!all_byte_write_n && s_d.state == SRP_ACTIVE && !ads_p && !s_q.wr_inhibit)
        |=> (s_q.wr && s_q.wlane == 4'hf))
        else $error("all-byte write missed a lane");

    chk_sleep_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
        sleep_request |=> (s_q.state == SRP_SLEEP && !dq_oe && !s_q.wr))
        else $error("sleep did not quiet the port");

    chk_oe_hiz: assert property (@(posedge hclk) disable iff (!hresetn)
        output_enable_n |=> !dq_oe)
        else $error("drove pins with output enable high");

    chk_desel_mask: assert property (@(posedge hclk) disable iff (!hresetn)
        leave_desel |=> !dq_oe)
        else $error("drove pins in first clock after deselection");

    chk_desel_hiz: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.state != SRP_ACTIVE) |-> !dq_oe && !parity_io_lines_oe)
        else $error("deselected port drove its pins");

    chk_linear_step: assert property (@(posedge hclk) disable iff (!hresetn)
        (burst_step && !s_q.ilv && !sleep_request) |=> (off_q == 2'($past(off_q) + 2'h1)))
        else $error("linear burst did not count up");

    chk_ilv_order: assert property (@(posedge hclk) disable iff (!hresetn)
        ilv_load_one ##1 (burst_step && !sleep_request) |=> (off_q == 2'h0))
        else $error("interleaved burst order is wrong");

endmodule
`default_nettype wire
